// ### spm_consts.vh
// constants for the send path peak monitor register bank
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// register indices as printed; byte address is four times the index
`define SPM_IDX_SEND_IN_PEAK_LOW 8'h36
`define SPM_IDX_SEND_IN_PEAK_HIGH 8'h37
`define SPM_IDX_SEND_ERROR_PEAK_LOW 8'h38
`define SPM_IDX_SEND_ERROR_PEAK_HIGH 8'h39
`define SPM_IDX_PEAK_CONTROL 8'h30
`define SPM_IDX_PEAK_STATUS 8'h31

// reset values
`define SPM_RST_PEAK_BYTE 8'h00
`define SPM_RST_PEAK_VALUE 16'h0000
`define SPM_RST_DECAY_SHIFT 4'h8
`define SPM_RST_SAMPLE_COUNT 16'h0000

// byte lanes of a 16 bit peak value
`define SPM_LOW_BYTE_MSB 7
`define SPM_LOW_BYTE_LSB 0
`define SPM_HIGH_BYTE_MSB 15
`define SPM_HIGH_BYTE_LSB 8

// control register fields
`define SPM_CTRL_FREEZE_BIT 0
`define SPM_CTRL_DECAY_EN_BIT 1
`define SPM_CTRL_SHIFT_LSB 2
`define SPM_CTRL_SHIFT_MSB 5
`define SPM_CTRL_CLEAR_BIT 8

// status register fields
`define SPM_STAT_COUNT_LSB 0
`define SPM_STAT_COUNT_MSB 15
`define SPM_STAT_FROZEN_BIT 16
`define SPM_STAT_DECAY_BIT 17

// bus geometry
`define SPM_WORD_LSB 2
`define SPM_DATA_ZERO 32'h0000_0000

`endif

// ### spm_peak_track.v
// one peak tracker: holds the largest magnitude seen, with optional decay
module spm_peak_track #(
  parameter WIDTH = 16,
  parameter SHIFT_W = 4
) (
  input wire clk_sys,
  input wire srst,
  input wire sampleValid,
  input wire [WIDTH-1:0] sampleIn,
  input wire freeze,
  input wire decayEnable,
  input wire [SHIFT_W-1:0] decayShift,
  input wire clearPeak,
  output reg [WIDTH-1:0] peakValue
);

  localparam [WIDTH-1:0] MOST_NEG = {1'b1, {(WIDTH-1){1'b0}}};
  localparam [WIDTH-1:0] MOST_POS = {1'b0, {(WIDTH-1){1'b1}}};
  localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};

  reg [WIDTH-1:0] magnitude;
  reg [WIDTH-1:0] basePeak;
  reg [WIDTH-1:0] decayed;
  reg [WIDTH-1:0] next_peakValue;

  // absolute value; the most negative code saturates so the peak stays positive
  always @* begin
    if (sampleIn == MOST_NEG) begin
      magnitude = MOST_POS;
    end else if (sampleIn[WIDTH-1]) begin
      magnitude = ZERO - sampleIn;
    end else begin
      magnitude = sampleIn;
    end
  end

  // clear and decay act first, then a new sample may raise the peak
  always @* begin
    basePeak = clearPeak ? ZERO : peakValue;
    decayed = basePeak;
    next_peakValue = basePeak;
    if (sampleValid && !freeze) begin
      if (decayEnable) begin
        decayed = basePeak - (basePeak >> decayShift);
      end
      next_peakValue = (magnitude > decayed) ? magnitude : decayed;
    end
  end

  // peak register, zero after reset
  always @(posedge clk_sys) begin
    if (srst) begin
      peakValue <= ZERO;
    end else begin
      peakValue <= next_peakValue;
    end
  end

endmodule

// ### spm_monitor.v
// send path peak monitor: two peak trackers behind an apb register bank
//
// Summary of operation
// - The peak of the send input signal is readable as a read-only register pair.
// - The peak of the send error signal after cancellation is a second read-only pair.
// - Each peak is a 16-bit two's complement value shown as two 8-bit registers.
// - The lower-addressed register of a pair gives bits 7..0, the higher one bits 15..8.
// - Every peak byte reads 00h after reset, msb in bit 7 and lsb in bit 0.
//
// The APB interface to the registers was left to the implementer.
`include "spm_consts.vh"

module spm_monitor #(
  parameter DATA_W = 16,
  parameter ADDR_W = 12,
  parameter SHIFT_W = 4,
  parameter COUNT_W = 16
) (
  input wire clk_sys,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire sampleValid,
  input wire [DATA_W-1:0] sendInSample,
  input wire [DATA_W-1:0] sendErrorSample,
  output wire [DATA_W-1:0] sendInPeakOut,
  output wire [DATA_W-1:0] sendErrorPeakOut
);

  // byte addresses derived from the printed indices
  localparam [ADDR_W-1:0] ADDR_IN_LOW =
    {{(ADDR_W-10){1'b0}}, `SPM_IDX_SEND_IN_PEAK_LOW, 2'b00};
  localparam [ADDR_W-1:0] ADDR_IN_HIGH =
    {{(ADDR_W-10){1'b0}}, `SPM_IDX_SEND_IN_PEAK_HIGH, 2'b00};
  localparam [ADDR_W-1:0] ADDR_ERR_LOW =
    {{(ADDR_W-10){1'b0}}, `SPM_IDX_SEND_ERROR_PEAK_LOW, 2'b00};
  localparam [ADDR_W-1:0] ADDR_ERR_HIGH =
    {{(ADDR_W-10){1'b0}}, `SPM_IDX_SEND_ERROR_PEAK_HIGH, 2'b00};
  localparam [ADDR_W-1:0] ADDR_CTRL =
    {{(ADDR_W-10){1'b0}}, `SPM_IDX_PEAK_CONTROL, 2'b00};
  localparam [ADDR_W-1:0] ADDR_STAT =
    {{(ADDR_W-10){1'b0}}, `SPM_IDX_PEAK_STATUS, 2'b00};

  localparam [COUNT_W-1:0] COUNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};

  // peak values from the two trackers
  wire [DATA_W-1:0] send_in_peak_value;
  wire [DATA_W-1:0] send_error_peak_value;

  // control state written by software
  reg freezePeaks;
  reg decayEnable;
  reg [SHIFT_W-1:0] decayShift;
  reg clearPulse;

  // status state
  reg [COUNT_W-1:0] sampleCount;

  // bus decode
  wire setupPhase;
  wire accessPhase;
  wire writeTaken;
  reg mapped;
  reg [31:0] next_prdata;
  wire ctrlWrite;

  // apb phases; the slave never inserts wait states
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign pready = 1'b1;
  assign writeTaken = accessPhase && pwrite && pready;

  // software only steers the control register; peak writes fall through
  assign ctrlWrite = writeTaken && (paddr == ADDR_CTRL);

  // live peak values for neighbouring logic
  assign sendInPeakOut = send_in_peak_value;
  assign sendErrorPeakOut = send_error_peak_value;

  // tracker for the send input signal where it enters the send path
  spm_peak_track #(
    .WIDTH(DATA_W),
    .SHIFT_W(SHIFT_W)
  ) sendInTrack (
    .clk_sys(clk_sys),
    .srst(srst),
    .sampleValid(sampleValid),
    .sampleIn(sendInSample),
    .freeze(freezePeaks),
    .decayEnable(decayEnable),
    .decayShift(decayShift),
    .clearPeak(clearPulse),
    .peakValue(send_in_peak_value)
  );

  // tracker for the residual after echo cancellation
  spm_peak_track #(
    .WIDTH(DATA_W),
    .SHIFT_W(SHIFT_W)
  ) sendErrorTrack (
    .clk_sys(clk_sys),
    .srst(srst),
    .sampleValid(sampleValid),
    .sampleIn(sendErrorSample),
    .freeze(freezePeaks),
    .decayEnable(decayEnable),
    .decayShift(decayShift),
    .clearPeak(clearPulse),
    .peakValue(send_error_peak_value)
  );

  // control register, byte lanes honoured; clear is a one cycle pulse
  always @(posedge clk_sys) begin
    if (srst) begin
      freezePeaks <= 1'b0;
      decayEnable <= 1'b0;
      decayShift <= `SPM_RST_DECAY_SHIFT;
      clearPulse <= 1'b0;
    end else begin
      clearPulse <= 1'b0;
      if (ctrlWrite && pstrb[0]) begin
        freezePeaks <= pwdata[`SPM_CTRL_FREEZE_BIT];
        decayEnable <= pwdata[`SPM_CTRL_DECAY_EN_BIT];
        decayShift <= pwdata[`SPM_CTRL_SHIFT_MSB:`SPM_CTRL_SHIFT_LSB];
      end
      if (ctrlWrite && pstrb[1]) begin
        clearPulse <= pwdata[`SPM_CTRL_CLEAR_BIT];
      end
    end
  end

  // count of samples seen, wraps
  always @(posedge clk_sys) begin
    if (srst) begin
      sampleCount <= `SPM_RST_SAMPLE_COUNT;
    end else if (sampleValid) begin
      sampleCount <= sampleCount + COUNT_ONE;
    end
  end

  // read mux; each peak byte sits in the low lane, upper bits zero
  always @* begin
    mapped = 1'b1;
    next_prdata = `SPM_DATA_ZERO;
    case (paddr)
      ADDR_IN_LOW: begin
        next_prdata[`SPM_LOW_BYTE_MSB:`SPM_LOW_BYTE_LSB] =
          send_in_peak_value[`SPM_LOW_BYTE_MSB:`SPM_LOW_BYTE_LSB];
      end
      ADDR_IN_HIGH: begin
        next_prdata[`SPM_LOW_BYTE_MSB:`SPM_LOW_BYTE_LSB] =
          send_in_peak_value[`SPM_HIGH_BYTE_MSB:`SPM_HIGH_BYTE_LSB];
      end
      ADDR_ERR_LOW: begin
        next_prdata[`SPM_LOW_BYTE_MSB:`SPM_LOW_BYTE_LSB] =
          send_error_peak_value[`SPM_LOW_BYTE_MSB:`SPM_LOW_BYTE_LSB];
      end
      ADDR_ERR_HIGH: begin
        next_prdata[`SPM_LOW_BYTE_MSB:`SPM_LOW_BYTE_LSB] =
          send_error_peak_value[`SPM_HIGH_BYTE_MSB:`SPM_HIGH_BYTE_LSB];
      end
      ADDR_CTRL: begin
        next_prdata[`SPM_CTRL_FREEZE_BIT] = freezePeaks;
        next_prdata[`SPM_CTRL_DECAY_EN_BIT] = decayEnable;
        next_prdata[`SPM_CTRL_SHIFT_MSB:`SPM_CTRL_SHIFT_LSB] = decayShift;
      end
      ADDR_STAT: begin
        next_prdata[`SPM_STAT_COUNT_MSB:`SPM_STAT_COUNT_LSB] = sampleCount;
        next_prdata[`SPM_STAT_FROZEN_BIT] = freezePeaks;
        next_prdata[`SPM_STAT_DECAY_BIT] = decayEnable;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data and error are captured in the setup cycle and stand through access
  always @(posedge clk_sys) begin
    if (srst) begin
      prdata <= `SPM_DATA_ZERO;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? `SPM_DATA_ZERO : next_prdata;
      pslverr <= !mapped;
    end
  end

endmodule

// ### spm_monitor_props.sv
// assertions on the send path peak monitor ports
`include "spm_consts.vh"
module spm_monitor_props (
  input wire clk_sys,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire sampleValid,
  input wire [15:0] sendInSample,
  input wire [15:0] sendInPeakOut,
  input wire [15:0] sendErrorPeakOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  localparam logic [11:0] AIL = {2'h0, `SPM_IDX_SEND_IN_PEAK_LOW, 2'h0};
  localparam logic [11:0] AEH = {2'h0, `SPM_IDX_SEND_ERROR_PEAK_HIGH, 2'h0};
  // byte lanes and magnitude of the watched values
  wire [7:0] inLo = sendInPeakOut[7:0];
  wire [7:0] inHi = sendInPeakOut[15:8];
  wire [7:0] erLo = sendErrorPeakOut[7:0];
  wire [7:0] erHi = sendErrorPeakOut[15:8];
  wire [15:0] inMag = sendInSample == 16'h8000 ? 16'h7fff
    : (sendInSample[15] ? -sendInSample : sendInSample);
  sequence rdSetup(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  chk_in_low: assert property (rdSetup(AIL) |=> prdata == {24'h0, $past(inLo)})
    else $error("send input low byte wrong");
  chk_in_high: assert property (rdSetup(AIL + 12'h4) |=> prdata == {24'h0, $past(inHi)})
    else $error("send input high byte wrong");
  chk_err_low: assert property (rdSetup(AEH - 12'h4) |=> prdata == {24'h0, $past(erLo)})
    else $error("send error low byte wrong");
  chk_err_high: assert property (rdSetup(AEH)
    |=> prdata == {24'h0, $past(erHi)} && !pslverr)
    else $error("send error high read wrong");
  chk_reset_zero: assert property ($fell(srst) |-> sendInPeakOut == 16'h0
    && sendErrorPeakOut == 16'h0 && prdata == 32'h0 && !pslverr)
    else $error("peak not zero after reset");
  chk_write_ignored: assert property (psel && penable && pwrite
    && paddr >= AIL && paddr <= AEH && !sampleValid
    |=> $stable(sendInPeakOut) && $stable(sendErrorPeakOut))
    else $error("peak changed by a write");
  chk_peak_rise: assert property (sampleValid && inMag > sendInPeakOut
    |=> sendInPeakOut == $past(inMag))
    else $error("peak did not follow sample");
endmodule

bind spm_monitor spm_monitor_props chk_u (.clk_sys(clk_sys), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .sampleValid(sampleValid), .sendInSample(sendInSample), .sendInPeakOut(sendInPeakOut),
  .sendErrorPeakOut(sendErrorPeakOut));

// ### tb_send_path_peak_monitor.sv
// self-checking bench for the send path peak monitor
`include "spm_consts.vh"
module tb_send_path_peak_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, sampleValid = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, r;
  logic [15:0] sendInSample = 0, sendErrorSample = 0, expIn = 0, expErr = 0, e, nSamp = 0;
  logic [3:0] pstrb = 4'hf;
  logic frz = 0;
  wire pready, pslverr;
  wire [31:0] prdata;
  wire [15:0] sendInPeakOut, sendErrorPeakOut;
  int error_cnt = 0, tests_run = 0, cycles = 0, dsh = 0;
  logic [7:0] idx[4] = '{`SPM_IDX_SEND_IN_PEAK_LOW, `SPM_IDX_SEND_IN_PEAK_HIGH,
    `SPM_IDX_SEND_ERROR_PEAK_LOW, `SPM_IDX_SEND_ERROR_PEAK_HIGH};
  spm_monitor dut_u (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sampleValid(sampleValid),
    .sendInSample(sendInSample), .sendErrorSample(sendErrorSample),
    .sendInPeakOut(sendInPeakOut), .sendErrorPeakOut(sendErrorPeakOut));
  // 25 mhz clock
  always #20 clk_sys = ~clk_sys;
  // cycle ceiling cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      wrap_up();
    end
  end
  function automatic logic [15:0] mag(input logic [15:0] x);
    return x == 16'h8000 ? 16'h7fff : (x[15] ? -x : x);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // read all four peak bytes against the model
  task automatic chk_peaks();
    for (int i = 0; i < 4; i++) begin
      e = i < 2 ? expIn : expErr;
      apb(0, idx[i], 32'h0);
      check(rd, {24'h0, i[0] ? e[15:8] : e[7:0]});
      check({31'h0, err}, 32'h0);
    end
    check({sendInPeakOut, sendErrorPeakOut}, {expIn, expErr});
  endtask
  // one sample pulse, then 8000h left on both sample inputs
  task automatic sample(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk_sys);
    sampleValid <= 1;
    sendInSample <= a;
    sendErrorSample <= b;
    @(posedge clk_sys);
    sampleValid <= 0;
    sendInSample <= 16'h8000;
    sendErrorSample <= 16'h8000;
    nSamp = nSamp + 16'h1;
    // frozen peaks ignore samples; decay acts before the new magnitude
    if (!frz) begin
      if (dsh > 0) begin
        expIn = expIn - (expIn >> dsh);
        expErr = expErr - (expErr >> dsh);
      end
      if (mag(a) > expIn) expIn = mag(a);
      if (mag(b) > expErr) expErr = mag(b);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    r = $urandom(32'h01f89ba9);
    repeat (2) @(posedge clk_sys);
    srst <= 0;
    chk_peaks();
    apb(0, `SPM_IDX_PEAK_CONTROL, 32'h0);
    check(rd, 32'h20);
    $display("reset test done");
    sample(16'hff00, 16'h0100);
    chk_peaks();
    for (int k = 0; k < 20; k++) begin
      r = $urandom;
      sample({{4{r[15]}}, r[11:0]}, {{4{r[31]}}, r[27:16]});
      chk_peaks();
    end
    sample(16'h8000, 16'h7fff);
    chk_peaks();
    $display("sample test done");
    for (int i = 0; i < 4; i++) begin
      apb(1, idx[i], $urandom);
      check({31'h0, err}, 32'h0);
    end
    chk_peaks();
    apb(0, 8'h3f, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("write and unmapped test done");
    // strobed clear, decay, freeze and status readback
    pstrb <= 4'h1;
    apb(1, `SPM_IDX_PEAK_CONTROL, 32'h120);
    chk_peaks();
    pstrb <= 4'h2;
    apb(1, `SPM_IDX_PEAK_CONTROL, 32'h100);
    pstrb <= 4'hf;
    expIn = 0;
    expErr = 0;
    chk_peaks();
    apb(1, `SPM_IDX_PEAK_CONTROL, 32'h6);
    dsh = 1;
    sample(16'h0400, 16'hfc00);
    sample(16'h0100, 16'h0000);
    chk_peaks();
    apb(1, `SPM_IDX_PEAK_CONTROL, 32'h7);
    frz = 1;
    sample(16'h0010, 16'h0010);
    chk_peaks();
    apb(0, `SPM_IDX_PEAK_CONTROL, 32'h0);
    check(rd, 32'h7);
    apb(0, `SPM_IDX_PEAK_STATUS, 32'h0);
    check(rd, {14'h0, 2'b11, nSamp});
    apb(1, `SPM_IDX_PEAK_CONTROL, 32'h20);
    dsh = 0;
    frz = 0;
    $display("control test done");
    @(posedge clk_sys);
    srst <= 1;
    repeat (2) @(posedge clk_sys);
    srst <= 0;
    expIn = 0;
    expErr = 0;
    chk_peaks();
    apb(0, `SPM_IDX_PEAK_STATUS, 32'h0);
    check(rd, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule
